// file: core/gpmc_pkg.sv
/*
  gpmc_pkg: shared constants, types and register map of the gauge power mode controller.
  Assumes one 40 MHz clock domain. Measurement words arrive from the measurement front end.
*/
package gpmc_pkg;
  localparam int unsigned clk_hz = 40000000;
  // time figures in their own units
  localparam int unsigned stretch_max_ms = 4;
  localparam int unsigned settle_s = 3;
  localparam int unsigned temp_hold_s = 60;
  localparam int unsigned stretch_cycles = stretch_max_ms * (clk_hz / 1000);
  localparam int unsigned settle_cycles = settle_s * clk_hz;
  localparam int unsigned temp_hold_cycles = temp_hold_s * clk_hz;
  // calibration and temperature thresholds (mA, mV, 0.1 degC)
  localparam logic signed [15:0] cal_cur_max_ma = 16'sh0064;
  localparam logic [15:0] cal_dv_mv = 16'h0100;
  localparam logic [15:0] cal_dt_dc = 16'h0050;
  localparam logic [15:0] cal_abort_mv = 16'h0020;
  localparam logic signed [15:0] cal_temp_lo_dc = 16'sh0032;
  localparam logic signed [15:0] cal_temp_hi_dc = 16'sh01c2;
  // register byte offsets
  localparam logic [7:0] reg_ctrl = 8'h00;
  localparam logic [7:0] reg_cfg = 8'h04;
  localparam logic [7:0] reg_sleep_cur = 8'h08;
  localparam logic [7:0] reg_hib_cur = 8'h0c;
  localparam logic [7:0] reg_hib_volt = 8'h10;
  localparam logic [7:0] reg_flash_volt = 8'h14;
  localparam logic [7:0] reg_ds_wait = 8'h18;
  localparam logic [7:0] reg_status = 8'h1c;
  localparam logic [7:0] reg_rst_cnt = 8'h20;
  localparam logic [7:0] reg_offset = 8'h24;
  // ctrl bits (write 1 to act)
  localparam int ctrl_hib_set = 0;
  localparam int ctrl_hib_clr = 1;
  localparam int ctrl_ds_set = 2;
  localparam int ctrl_shut_set = 3;
  localparam int ctrl_shut_clr = 4;
  localparam int ctrl_sw_reset = 5;
  localparam int ctrl_rst_type = 6;
  // cfg bits
  localparam int cfg_sleep_en = 0;
  localparam int cfg_polarity = 1;
  localparam int cfg_sel_lo = 2;
  localparam int cfg_sel_hi = 3;
  localparam int cfg_range = 4;
  localparam logic [31:0] cfg_reset = 32'h0000_0007;
  localparam logic [1:0] resp_okay = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;

  typedef enum {pm_normal, pm_cal, pm_sleep, pm_deep, pm_hib} gpmc_mode_t;

  typedef struct packed {
    logic signed [15:0] avg_cur_ma;
    logic [15:0] volt_mv;
    logic signed [15:0] temp_dc;
    logic signed [15:0] sense_raw;
    logic ocv_valid;
    logic sample;
  } gpmc_meas_t;
endpackage

// file: core/gpmc_top.sv
/*
  gpmc_top: power mode controller with AXI4-Lite registers.
  Assumes measurement samples and a wake comparator level from the front end;
  comm activity and comparator come from pins and are synchronised here.
*/
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module gpmc_top #(
  parameter int unsigned settle_len = gpmc_pkg::settle_cycles,
  parameter int unsigned temp_hold_len = gpmc_pkg::temp_hold_cycles,
  parameter int unsigned stretch_len = gpmc_pkg::stretch_cycles,
  parameter int unsigned cal_len = 64
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // measurements and pins
  input wire gpmc_pkg::gpmc_meas_t meas,
  input wire logic comm_activity_pin,
  input wire logic wake_cmp_pin,
  // power outputs
  output logic power_cut_pin,
  output logic power_cut_pin_oe_n,
  output logic hf_osc_en,
  output logic comm_stretch,
  output logic [2:0] wake_threshold_code,
  output logic flash_update_ok,
  output logic report_hold,
  output logic signed [15:0] sense_corrected,
  output logic [2:0] power_mode
);
  gpmc_pkg::gpmc_mode_t mode;
  logic [31:0] cfg, sleep_cur, hib_cur, hib_volt, flash_volt, ds_wait;
  logic hib_req, ds_en, shut_en;
  logic [15:0] rst_cnt [2];
  logic signed [15:0] offset;
  logic [2:0] comm_sy, cmp_sy;
  logic comm_act, cmp_trip;
  logic [31:0] ds_timer, settle_cnt, hold_cnt, stretch_cnt, cal_cnt;
  logic [15:0] cal_volt, cal_temp, cal_start_v;
  logic cal_single, cal_done, cal_abort;
  logic aw_hold, w_hold;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire, hib_entry, sleep_ok, cur_hib, volt_hib, temp_ok, drift;
  logic [15:0] abs_cur, dv, dt;

  // magnitude helper, used for current and deltas
  function automatic logic [15:0] mag(input logic signed [15:0] v);
    mag = v[15] ? 16'(-v) : 16'(v);
  endfunction

  // byte-lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = s[i] ? d[8*i +: 8] : o[8*i +: 8];
    end
  endfunction

  // three-stage synchronisers; only stages 2 and 3 are looked at
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      comm_sy <= 3'h0;
      cmp_sy <= 3'h0;
      comm_act <= 1'b0;
      cmp_trip <= 1'b0;
    end else begin
      comm_sy <= {comm_sy[1:0], comm_activity_pin};
      cmp_sy <= {cmp_sy[1:0], wake_cmp_pin};
      if (comm_sy[1] == comm_sy[2]) comm_act <= comm_sy[2];
      if (cmp_sy[1] == cmp_sy[2]) cmp_trip <= cmp_sy[2];
    end
  end

  // axi write channel capture: address and data taken in either order
  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready = !w_hold && !s_axi_bvalid;
  assign wr_fire = aw_hold && w_hold && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= gpmc_pkg::resp_okay;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr <= gpmc_pkg::reg_ds_wait) ? gpmc_pkg::resp_okay
                                                           : gpmc_pkg::resp_slverr;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // configuration registers; sleep enable and polarity default set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg <= gpmc_pkg::cfg_reset;
      sleep_cur <= 32'h0000_0000;
      hib_cur <= 32'h0000_0000;
      hib_volt <= 32'h0000_0000;
      flash_volt <= 32'h0000_0000;
      ds_wait <= 32'h0000_0000;
    end else if (wr_fire) begin
      case (aw_addr)
        gpmc_pkg::reg_cfg: cfg <= merge(cfg, w_data, w_strb);
        gpmc_pkg::reg_sleep_cur: sleep_cur <= merge(sleep_cur, w_data, w_strb);
        gpmc_pkg::reg_hib_cur: hib_cur <= merge(hib_cur, w_data, w_strb);
        gpmc_pkg::reg_hib_volt: hib_volt <= merge(hib_volt, w_data, w_strb);
        gpmc_pkg::reg_flash_volt: flash_volt <= merge(flash_volt, w_data, w_strb);
        gpmc_pkg::reg_ds_wait: ds_wait <= merge(ds_wait, w_data, w_strb);
        default: ;
      endcase
    end
  end

  // control status bits; a hardware clear on wake beats a host set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hib_req <= 1'b0;
      ds_en <= 1'b0;
      shut_en <= 1'b1;
    end else begin
      if (wr_fire && aw_addr == gpmc_pkg::reg_ctrl && w_strb[0]) begin
        if (w_data[gpmc_pkg::ctrl_hib_set]) hib_req <= 1'b1;
        if (w_data[gpmc_pkg::ctrl_hib_clr]) hib_req <= 1'b0;
        if (w_data[gpmc_pkg::ctrl_ds_set]) ds_en <= 1'b1;
        if (w_data[gpmc_pkg::ctrl_shut_set]) shut_en <= 1'b1;
        if (w_data[gpmc_pkg::ctrl_shut_clr]) shut_en <= 1'b0;
      end
      if (mode == gpmc_pkg::pm_hib && comm_act) hib_req <= 1'b0;
      if (mode == gpmc_pkg::pm_deep && comm_act) ds_en <= 1'b0;
    end
  end

  // software reset counters, one per reset type
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_cnt[0] <= 16'h0000;
      rst_cnt[1] <= 16'h0000;
    end else if (wr_fire && aw_addr == gpmc_pkg::reg_ctrl && w_strb[0]
                 && w_data[gpmc_pkg::ctrl_sw_reset]) begin
      rst_cnt[w_data[gpmc_pkg::ctrl_rst_type]] <= rst_cnt[w_data[gpmc_pkg::ctrl_rst_type]]
                                                  + 16'h0001;
    end
  end

  // entry qualifiers
  assign abs_cur = mag(meas.avg_cur_ma);
  assign sleep_ok = cfg[gpmc_pkg::cfg_sleep_en]
                    && (meas.avg_cur_ma < $signed(sleep_cur[15:0]));
  assign cur_hib = hib_req && meas.ocv_valid && (abs_cur < hib_cur[15:0]);
  assign volt_hib = meas.ocv_valid && (meas.volt_mv < hib_volt[15:0]);
  assign hib_entry = cur_hib || volt_hib;
  assign temp_ok = (meas.temp_dc > gpmc_pkg::cal_temp_lo_dc)
                   && (meas.temp_dc < gpmc_pkg::cal_temp_hi_dc);
  assign dv = mag($signed(meas.volt_mv - cal_volt));
  assign dt = mag($signed(meas.temp_dc - $signed(cal_temp)));
  assign drift = (abs_cur <= 16'(gpmc_pkg::cal_cur_max_ma) || !meas.avg_cur_ma[15])
                 && meas.avg_cur_ma <= gpmc_pkg::cal_cur_max_ma
                 && (dv >= gpmc_pkg::cal_dv_mv || hold_cnt >= temp_hold_len);
  assign cal_done = (cal_cnt == cal_len - 1);
  assign cal_abort = (cal_start_v > meas.volt_mv)
                     && (cal_start_v - meas.volt_mv > gpmc_pkg::cal_abort_mv);

  // temperature drift persistence counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_cnt <= 32'h0000_0000;
    end else if (mode == gpmc_pkg::pm_cal || dt <= gpmc_pkg::cal_dt_dc) begin
      hold_cnt <= 32'h0000_0000;
    end else if (hold_cnt < temp_hold_len) begin
      hold_cnt <= hold_cnt + 32'h0000_0001;
    end
  end

  // mode sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= gpmc_pkg::pm_normal;
      ds_timer <= 32'h0000_0000;
      cal_cnt <= 32'h0000_0000;
      cal_single <= 1'b0;
      cal_start_v <= 16'h0000;
    end else begin
      case (mode)
        gpmc_pkg::pm_normal: begin
          if (hib_entry) begin
            mode <= gpmc_pkg::pm_hib;
          end else if ((sleep_ok && temp_ok) || drift) begin
            mode <= gpmc_pkg::pm_cal;
            cal_single <= !sleep_ok;
            cal_cnt <= 32'h0000_0000;
            cal_start_v <= meas.volt_mv;
          end else if (sleep_ok) begin
            mode <= gpmc_pkg::pm_sleep;
            ds_timer <= ds_wait;
          end
        end
        gpmc_pkg::pm_cal: begin
          cal_cnt <= cal_cnt + 32'h0000_0001;
          if (hib_entry) begin
            mode <= gpmc_pkg::pm_hib;
          end else if (cal_abort) begin
            mode <= gpmc_pkg::pm_normal;
          end else if (cal_done) begin
            mode <= (!cal_single && sleep_ok) ? gpmc_pkg::pm_sleep : gpmc_pkg::pm_normal;
            ds_timer <= ds_wait;
          end
        end
        gpmc_pkg::pm_sleep: begin
          if (hib_entry) begin
            mode <= gpmc_pkg::pm_hib;
          end else if (!sleep_ok || cmp_trip) begin
            mode <= gpmc_pkg::pm_normal;
          end else if (ds_en && ($signed(ds_timer) <= 0)) begin
            mode <= gpmc_pkg::pm_deep;
          end else if (ds_en) begin
            ds_timer <= ds_timer - 32'h0000_0001;
          end
        end
        gpmc_pkg::pm_deep: begin
          if (hib_entry) mode <= gpmc_pkg::pm_hib;
          else if (comm_act) mode <= gpmc_pkg::pm_normal;
        end
        gpmc_pkg::pm_hib: begin
          if (comm_act) mode <= gpmc_pkg::pm_normal;
        end
        default: mode <= gpmc_pkg::pm_normal;
      endcase
    end
  end

  // calibration snapshot and offset store; measurements keep flowing meanwhile
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cal_volt <= 16'h0000;
      cal_temp <= 16'h0000;
      offset <= 16'sh0000;
    end else if (mode == gpmc_pkg::pm_cal && cal_done && !cal_abort) begin
      cal_volt <= meas.volt_mv;
      cal_temp <= meas.temp_dc;
      offset <= meas.sense_raw;
    end
  end

  // corrected sense reading, updated on every sample outside calibration
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sense_corrected <= 16'sh0000;
    end else if (meas.sample && mode != gpmc_pkg::pm_cal) begin
      sense_corrected <= meas.sense_raw - offset;
    end
  end

  // post-hibernate settle window holds reported values
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settle_cnt <= 32'h0000_0000;
    end else if (mode == gpmc_pkg::pm_hib && comm_act) begin
      settle_cnt <= settle_len;
    end else if (settle_cnt != 0) begin
      settle_cnt <= settle_cnt - 32'h0000_0001;
    end
  end

  // clock stretch on comm activity while sleeping, bounded
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stretch_cnt <= 32'h0000_0000;
    end else if ((mode == gpmc_pkg::pm_sleep || mode == gpmc_pkg::pm_deep) && comm_act
                 && stretch_cnt == 0) begin
      stretch_cnt <= stretch_len;
    end else if (stretch_cnt != 0) begin
      stretch_cnt <= stretch_cnt - 32'h0000_0001;
    end
  end

  // registered outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_cut_pin <= 1'b0;
      power_cut_pin_oe_n <= 1'b1;
      hf_osc_en <= 1'b1;
      comm_stretch <= 1'b0;
      wake_threshold_code <= 3'h0;
      flash_update_ok <= 1'b0;
      report_hold <= 1'b0;
      power_mode <= 3'h0;
    end else begin
      // shutdown level only in hibernate; elsewhere the opposite, normal level
      power_cut_pin <= (mode == gpmc_pkg::pm_hib && shut_en)
                       ? cfg[gpmc_pkg::cfg_polarity]
                       : !cfg[gpmc_pkg::cfg_polarity];
      power_cut_pin_oe_n <= 1'b0;
      hf_osc_en <= (mode != gpmc_pkg::pm_deep && mode != gpmc_pkg::pm_hib);
      comm_stretch <= (stretch_cnt > 1);
      wake_threshold_code <= {cfg[gpmc_pkg::cfg_sel_hi], cfg[gpmc_pkg::cfg_sel_lo],
                              cfg[gpmc_pkg::cfg_range]};
      flash_update_ok <= (meas.volt_mv >= flash_volt[15:0]);
      report_hold <= (settle_cnt > 1);
      power_mode <= 3'(mode);
    end
  end

  // read channel, one cycle latency
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= gpmc_pkg::resp_okay;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= gpmc_pkg::resp_okay;
      case (s_axi_araddr)
        gpmc_pkg::reg_ctrl: s_axi_rdata <= 32'h0000_0000;
        gpmc_pkg::reg_cfg: s_axi_rdata <= cfg;
        gpmc_pkg::reg_sleep_cur: s_axi_rdata <= sleep_cur;
        gpmc_pkg::reg_hib_cur: s_axi_rdata <= hib_cur;
        gpmc_pkg::reg_hib_volt: s_axi_rdata <= hib_volt;
        gpmc_pkg::reg_flash_volt: s_axi_rdata <= flash_volt;
        gpmc_pkg::reg_ds_wait: s_axi_rdata <= ds_wait;
        gpmc_pkg::reg_status: s_axi_rdata <= {24'h000000, shut_en, ds_en, hib_req,
                                              flash_update_ok, 1'b0, power_mode};
        gpmc_pkg::reg_rst_cnt: s_axi_rdata <= {rst_cnt[1], rst_cnt[0]};
        gpmc_pkg::reg_offset: s_axi_rdata <= {{16{offset[15]}}, offset};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= gpmc_pkg::resp_slverr;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // gpmc_top

// file: tb/gpmc_checker.sv
/*
  gpmc_checker: port-level assertions for the power mode controller.
  Assumes it is bound into gpmc_top and sees only that module's ports.
*/
`timescale 1ns/1ps
module gpmc_checker #(
  parameter int unsigned stretch_len = 10,
  parameter int unsigned cal_len = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // watched outputs
  input wire logic [2:0] power_mode,
  input wire logic hf_osc_en,
  input wire logic comm_stretch,
  input wire logic report_hold,
  input wire logic power_cut_pin_oe_n,
  // response handshakes
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [15:0] cal_run;
  logic [15:0] str_run;
  // run lengths; a run that never ends shows up as a growing count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cal_run <= 16'h0000;
      str_run <= 16'h0000;
    end else begin
      cal_run <= (power_mode == 3'h1) ? cal_run + 16'h0001 : 16'h0000;
      str_run <= comm_stretch ? str_run + 16'h0001 : 16'h0000;
    end
  end
  sequence hib_exit;
    $past(power_mode) == 3'h4 && power_mode != 3'h4;
  endsequence
  sequence hold_rise;
    $rose(report_hold);
  endsequence
  mode_range_a: assert property (power_mode <= 3'h4)
    else $error("power mode out of range");
  osc_off_a: assert property (power_mode == 3'h3 && $past(power_mode) == 3'h3 |-> !hf_osc_en)
    else $error("oscillator running in deep sleep");
  deep_entry_a: assert property ($changed(power_mode) && power_mode == 3'h3 |->
    $past(power_mode) == 3'h2)
    else $error("deep sleep entered from a mode other than sleep");
  deep_exit_a: assert property ($past(power_mode) == 3'h3 && $changed(power_mode) |->
    power_mode inside {3'h0, 3'h4})
    else $error("deep sleep left to a wrong mode");
  hib_exit_a: assert property (hib_exit |-> power_mode == 3'h0)
    else $error("hibernate left to a mode other than normal");
  hold_after_hib_a: assert property (hold_rise |->
    $past(power_mode) == 3'h4 || $past(power_mode, 2) == 3'h4)
    else $error("report hold raised without hibernate exit");
  hold_len_a: assert property (hold_rise |-> report_hold [*8])
    else $error("report hold dropped too early");
  cal_len_a: assert property (cal_run <= cal_len + 1)
    else $error("calibration runs too long");
  cal_exit_a: assert property ($past(power_mode) == 3'h1 && $changed(power_mode) |->
    power_mode inside {3'h0, 3'h2, 3'h4})
    else $error("calibration left to a wrong mode");
  stretch_mode_a: assert property ($rose(comm_stretch) |->
    $past(power_mode) inside {3'h2, 3'h3})
    else $error("stretch outside sleep modes");
  stretch_len_a: assert property (str_run <= stretch_len + 1)
    else $error("stretch held too long");
  pin_drive_a: assert property ($past(aresetn) |-> !power_cut_pin_oe_n)
    else $error("power cut pin not driven");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response withdrawn");
  rresp_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read response withdrawn");
endmodule // gpmc_checker

bind gpmc_top gpmc_checker #(.stretch_len(stretch_len), .cal_len(cal_len)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .power_mode(power_mode), .hf_osc_en(hf_osc_en),
  .comm_stretch(comm_stretch), .report_hold(report_hold),
  .power_cut_pin_oe_n(power_cut_pin_oe_n), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// file: tb/gpmc_host_model.sv
/*
  gpmc_host_model: host on the comm lines, makes bursts of line activity.
  Assumes a one-cycle req from the bench; it tolerates stretching by waiting.
*/
`timescale 1ns/1ps
module gpmc_host_model #(
  parameter int unsigned burst_len = 6
) (
  // clock
  input wire logic aclk,
  // bench control
  input wire logic req,
  output logic busy,
  // comm lines
  input wire logic comm_stretch,
  output logic comm_activity_pin
);
  // burst long enough to pass the input synchroniser, then wait out the stretch
  // the single wire link is not used, so hibernate stays a bench decision
  initial begin
    comm_activity_pin = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge aclk);
      if (req) begin
        busy <= 1'b1;
        comm_activity_pin <= 1'b1;
        repeat (burst_len) @(posedge aclk);
        comm_activity_pin <= 1'b0;
        // stretch shows only a few cycles after the burst began, so look once it must stand
        repeat (4) @(posedge aclk);
        while (comm_stretch !== 1'b0) @(posedge aclk);
        busy <= 1'b0;
      end
    end
  end
endmodule // gpmc_host_model

// file: tb/tb.sv
/*
  tb: register-level tests of the power mode controller.
  Assumes short counts: settle 20, stretch 10, calibration 8 cycles.
*/
`timescale 1ns/1ps
module tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic wake_cmp_pin = 1'b0;
  logic host_req = 1'b0;
  gpmc_pkg::gpmc_meas_t meas = '{16'sh01f4, 16'h0ed8, 16'sh00fa, 16'sh0040, 1'b0, 1'b1};
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic comm_activity_pin, host_busy, power_cut_pin, power_cut_pin_oe_n, hf_osc_en;
  logic comm_stretch, flash_update_ok, report_hold;
  logic [2:0] wake_threshold_code, power_mode;
  logic signed [15:0] sense_corrected;
  int cyc = 0;
  int seen [5], seen_str, t0;
  logic [31:0] d, d0;
  logic [1:0] r;
  int err_count = 0;
  int n_tests = 0;
  int wn;

  gpmc_top #(.settle_len(20), .temp_hold_len(20), .stretch_len(10), .cal_len(8)) dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .meas, .comm_activity_pin, .wake_cmp_pin, .power_cut_pin,
    .power_cut_pin_oe_n, .hf_osc_en, .comm_stretch, .wake_threshold_code, .flash_update_ok,
    .report_hold, .sense_corrected, .power_mode);
  gpmc_host_model u_host (.aclk, .req(host_req), .busy(host_busy), .comm_stretch,
    .comm_activity_pin);

  // 25 ns clock
  initial begin
    forever #12.5 aclk = ~aclk;
  end
  // stamp the cycle each mode and stretch was last seen; only this process writes them
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (power_mode <= 3'h4) seen[power_mode] <= cyc;
    if (comm_stretch === 1'b1) seen_str <= cyc;
  end

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_tests++;
    if (got !== ex) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic clk(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // both channels offered together, each released at its own ready
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // bounded wait for a mode; wn keeps the cycles it took
  task automatic wait_mode(input logic [2:0] m, input int lim);
    wn = 0;
    while (power_mode !== m && wn < lim) begin
      @(posedge aclk);
      wn++;
    end
    chk("power mode", {29'h0, m}, {29'h0, power_mode});
  endtask
  task automatic poke();
    @(posedge aclk);
    host_req <= 1'b1;
    @(posedge aclk);
    host_req <= 1'b0;
    @(posedge aclk);
    while (host_busy !== 1'b0) @(posedge aclk);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge aclk);
    err_count++;
    $display("watchdog expired");
    finish_test();
  end

  initial begin
    clk(20);
    aresetn <= 1'b1;
    rd(8'h04);
    chk("cfg reset", 32'h7, d);
    chk("idle mode", 32'h0, {29'h0, power_mode});
    rd(8'h40);
    chk("unmapped read", {30'h0, gpmc_pkg::resp_slverr}, {30'h0, r});
    wr(8'h1c, 32'h1);
    chk("read only write", {30'h0, gpmc_pkg::resp_slverr}, {30'h0, r});
    for (int i = 0; i < 8; i++) begin
      wr(8'h04, {27'h0, i[0], i[2], i[1], 2'b11});
      clk(1);
      chk("wake code", i, {29'h0, wake_threshold_code});
    end
    wr(8'h04, 32'h7);
    wr(8'h14, 32'h0bb8);
    meas.volt_mv <= 16'h0bb8;
    clk(3);
    chk("flash at level", 32'h1, {31'h0, flash_update_ok});
    meas.volt_mv <= 16'h0bb7;
    clk(3);
    chk("flash below level", 32'h0, {31'h0, flash_update_ok});
    meas.volt_mv <= 16'h0ed8;
    $display("test registers done");
    wr(8'h08, 32'h0032);
    t0 = cyc;
    meas.avg_cur_ma <= 16'sh000a;
    wait_mode(3'h2, 200);
    chk("calibration first", 32'h1, {31'h0, seen[1] >= t0});
    wake_cmp_pin <= 1'b1;
    wait_mode(3'h0, 50);
    wake_cmp_pin <= 1'b0;
    wait_mode(3'h2, 200);
    meas.avg_cur_ma <= 16'sh0064;
    wait_mode(3'h0, 50);
    for (int i = 0; i < 2; i++) begin
      meas.temp_dc <= i ? 16'sh01c2 : 16'sh0032;
      t0 = cyc;
      meas.avg_cur_ma <= 16'sh000a;
      wait_mode(3'h2, 200);
      chk("calibration skipped", 32'h0, {31'h0, seen[1] >= t0});
      meas.avg_cur_ma <= 16'sh01f4;
      wait_mode(3'h0, 50);
    end
    meas.temp_dc <= 16'sh00fa;
    meas.avg_cur_ma <= 16'sh000a;
    wait_mode(3'h1, 50);
    meas.volt_mv <= 16'h0eb0;
    wait_mode(3'h0, 20);
    meas.avg_cur_ma <= 16'sh01f4;
    meas.volt_mv <= 16'h0ed8;
    wait_mode(3'h0, 50);
    $display("test sleep done");
    for (int i = 0; i < 2; i++) begin
      wr(8'h18, i ? 32'hffffffff : 32'h28);
      wr(8'h00, 32'h4);
      t0 = cyc;
      meas.avg_cur_ma <= 16'sh000a;
      wait_mode(3'h2, 200);
      wait_mode(3'h3, 200);
      chk("deep wait", 32'h1, {31'h0, i ? wn <= 3 : wn >= 20});
      clk(2);
      chk("osc off", 32'h0, {31'h0, hf_osc_en});
      meas.avg_cur_ma <= 16'sh01f4;
      poke();
      chk("stretch seen", 32'h1, {31'h0, seen_str >= t0});
      wait_mode(3'h0, 50);
    end
    $display("test deep sleep done");
    wr(8'h04, 32'h6);
    wr(8'h0c, 32'h0032);
    meas.avg_cur_ma <= 16'shfff6;
    clk(20);
    chk("no request", 32'h0, {29'h0, power_mode});
    wr(8'h00, 32'h9);
    clk(20);
    chk("no ocv", 32'h0, {29'h0, power_mode});
    wr(8'h00, 32'h2);
    meas.ocv_valid <= 1'b1;
    clk(20);
    chk("request withdrawn", 32'h0, {29'h0, power_mode});
    wr(8'h00, 32'h1);
    wait_mode(3'h4, 50);
    clk(2);
    chk("cut pin high", 32'h1, {31'h0, power_cut_pin});
    poke();
    wait_mode(3'h0, 50);
    chk("hold on", 32'h1, {31'h0, report_hold});
    rd(8'h1c);
    chk("request cleared", 32'h0, {31'h0, d[5]});
    clk(30);
    chk("hold off", 32'h0, {31'h0, report_hold});
    chk("no rearm", 32'h0, {29'h0, power_mode});
    meas.avg_cur_ma <= 16'sh01f4;
    wr(8'h04, 32'h5);
    wr(8'h10, 32'h0bb8);
    t0 = cyc;
    meas.avg_cur_ma <= 16'sh000a;
    meas.volt_mv <= 16'h0b54;
    wait_mode(3'h4, 50);
    chk("hibernate first", 32'h0, {30'h0, seen[2] >= t0, seen[1] >= t0});
    clk(2);
    chk("cut pin low", 32'h0, {31'h0, power_cut_pin});
    meas.volt_mv <= 16'h0ed8;
    meas.avg_cur_ma <= 16'sh01f4;
    poke();
    wait_mode(3'h0, 50);
    $display("test hibernate done");
    rd(8'h20);
    d0 = d;
    wr(8'h00, 32'h20);
    wr(8'h00, 32'h20);
    wr(8'h00, 32'h60);
    rd(8'h20);
    chk("type0 count", {16'h0, d0[15:0] + 16'h2}, {16'h0, d[15:0]});
    chk("type1 count", {16'h0, d0[31:16] + 16'h1}, {16'h0, d[31:16]});
    rd(8'h24);
    chk("offset", 32'h0000_0040, d);
    meas.sense_raw <= 16'sh0100;
    clk(3);
    chk("sense corrected", 32'h0000_00c0, {16'h0, sense_corrected});
    $display("test reset count done");
    finish_test();
  end
endmodule // tb
